//--- core/hid_register_access_bank.sv
`timescale 1ns/1ns
module hid_register_access_bank #(
    parameter int DEBOUNCE_CYC = hid_bank_pkg::DEBOUNCE_CYCLES,
    parameter int EXT_HALF     = hid_bank_pkg::EXT_SLOW_HALF
) (
    input  wire logic                      clk,
    input  wire logic                      resetn,
    input  wire hid_bank_pkg::out_report_s out_report,
    input  wire logic                      out_report_valid,
    output hid_bank_pkg::in_report_s       in_report,
    output logic                           in_report_valid,
    input  wire logic                      in_report_taken,
    input  wire logic [15:0]               mcu_word,
    input  wire logic                      mcu_word_valid,
    input  wire logic                      mcu_read,
    output logic                           ext_ctrl_irq_n,
    output logic                           ext_ctrl_clk,
    output hid_bank_pkg::nvm_req_s         nvm_req,
    output logic                           nvm_req_valid,
    input  wire logic                      nvm_req_ready,
    input  wire logic [15:0]               nvm_rsp_data,
    input  wire logic                      nvm_rsp_valid,
    input  wire logic                      vol_up_button_n,
    input  wire logic                      vol_down_button_n,
    input  wire logic                      record_silence_button_n,
    input  wire logic                      play_silence_button_n,
    input  wire logic                      jack_sense_in,
    input  wire logic                      package_indicator_in,
    input  wire logic [1:0]                digital_in_rate,
    input  wire logic                      digital_in_record_allowed,
    output logic [3:0]                     gp_pin_out,
    output logic [3:0]                     gp_pin_oe_n,
    output hid_bank_pkg::audio_ctrl_s      audio_ctrl,
    output logic                           record_silenced
);
    import hid_bank_pkg::*;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    localparam int NPIN = NUM_BTN + 2;

    logic [NPIN-1:0] pin_a_q;
    logic [NPIN-1:0] pin_b_q;
    logic [NPIN-1:0] pin_raw;

    assign pin_raw = {package_indicator_in, jack_sense_in,
                      play_silence_button_n, record_silence_button_n,
                      vol_down_button_n, vol_up_button_n};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_a_q <= {2'b00, {NUM_BTN{1'b1}}};
            pin_b_q <= {2'b00, {NUM_BTN{1'b1}}};
        end else begin
            pin_a_q <= pin_raw;
            pin_b_q <= pin_a_q;
        end
    end

    logic               jack_s;
    logic               pkg_s;
    logic [NUM_BTN-1:0] btn_pressed;
    logic [NUM_BTN-1:0] btn_press;

    assign jack_s = pin_b_q[NUM_BTN];
    assign pkg_s  = pin_b_q[NUM_BTN+1];

    button_filter #(
        .N   (NUM_BTN),
        .CYC (DEBOUNCE_CYC)
    ) u_filter (
        .clk     (clk),
        .resetn  (resetn),
        .raw_n   (pin_b_q[NUM_BTN-1:0]),
        .pressed (btn_pressed),
        .press   (btn_press)
    );

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    nvm_state_e       st_q;
    nvm_state_e       st_d;
    logic [3:0][15:0] regs_q;
    logic [3:0][15:0] regs_d;
    nvm_req_s         req_q;
    nvm_req_s         req_d;
    in_report_s       rep_q;
    in_report_s       rep_d;
    logic             rvalid_q;
    logic             rvalid_d;
    logic             irq_q;
    logic             irq_d;
    logic             mute_q;
    logic             mute_d;
    logic             rec_q;
    logic             rec_d;
    logic [2:0]       src_q;
    logic [2:0]       src_d;

    logic        is_reg;
    logic        is_nvm;
    logic        reg_rd;
    logic        reg_wr;
    logic        nvm_go;
    logic        nvm_win;
    logic        access;
    logic [1:0]  ridx;
    logic [15:0] wword;
    logic [15:0] rview;

    assign ridx   = out_report.addr[1:0];
    assign wword  = {out_report.hi, out_report.lo};
    assign is_reg = ((out_report.cmd == CMD_REG_RD) || (out_report.cmd == CMD_REG_WR))
                    && (out_report.addr <= REG_ADDR_MAX);
    assign is_nvm = ((out_report.cmd == CMD_NVM_RD) || (out_report.cmd == CMD_NVM_WR))
                    && (out_report.addr <= NVM_ADDR_MAX);
    assign reg_rd = out_report_valid && is_reg && (out_report.cmd == CMD_REG_RD);
    assign reg_wr = out_report_valid && is_reg && (out_report.cmd == CMD_REG_WR);
    // a second nonvolatile command while one is in flight is dropped
    assign nvm_go  = out_report_valid && is_nvm && (st_q == ST_IDLE);
    assign nvm_win = (st_q == ST_WAIT) && nvm_rsp_valid;
    assign access  = reg_rd || reg_wr || nvm_go;

    // register 3 mixes stored enables with live status inputs
    function automatic logic [15:0] reg_view(input logic [1:0] idx);
        logic [15:0] v;
        v = regs_q[idx] & REG_WR_MASK[idx];
        if (idx == REG_OFS_OUTEN) begin
            v[8:7] = digital_in_rate;
            v[6]   = pkg_s;
            v[0]   = digital_in_record_allowed;
        end
        return v;
    endfunction

    assign rview = reg_view(ridx);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        regs_d   = regs_q;
        st_d     = st_q;
        req_d    = req_q;
        rep_d    = rep_q;
        rvalid_d = rvalid_q;
        irq_d    = irq_q;
        mute_d   = mute_q;
        rec_d    = rec_q;
        src_d    = src_q;

        if (reg_wr) begin
            regs_d[ridx] = (wword & REG_WR_MASK[ridx])
                         | (regs_q[ridx] & ~REG_WR_MASK[ridx]);
        end

        case (st_q)
            ST_IDLE: begin
                if (nvm_go) begin
                    req_d.write = (out_report.cmd == CMD_NVM_WR);
                    req_d.addr  = out_report.addr[5:0];
                    req_d.data  = wword;
                    st_d        = ST_REQ;
                end
            end
            ST_REQ: begin
                if (nvm_req_ready) begin
                    st_d = req_q.write ? ST_IDLE : ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (nvm_rsp_valid) begin
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase

        if (rvalid_q && in_report_taken) begin
            rvalid_d = 1'b0;
            mute_d   = 1'b0;
        end
        // one report slot: nvm data first, then register, then controller
        if (nvm_win) begin
            src_d    = 3'b010;
            rep_d.lo = nvm_rsp_data[7:0];
            rep_d.hi = nvm_rsp_data[15:8];
            rvalid_d = 1'b1;
        end else if (reg_rd) begin
            src_d    = 3'b001;
            rep_d.lo = rview[7:0];
            rep_d.hi = rview[15:8];
            rvalid_d = 1'b1;
        end else if (mcu_word_valid) begin
            src_d    = 3'b100;
            rep_d.lo = mcu_word[7:0];
            rep_d.hi = mcu_word[15:8];
            rvalid_d = 1'b1;
        end

        if (btn_press[BTN_PLAY]) begin
            mute_d = 1'b1;
        end
        if (btn_press[BTN_REC]) begin
            rec_d = ~rec_q;
        end

        if (mcu_read) begin
            irq_d = 1'b0;
        end
        if (access) begin
            irq_d = 1'b1;
        end

        rep_d.flags            = '0;
        rep_d.flags[FLG_CTRL]  = src_d[2];
        rep_d.flags[FLG_NVM]   = src_d[1];
        rep_d.flags[FLG_REG]   = src_d[0];
        rep_d.flags[FLG_PHONE] = jack_s;
        rep_d.flags[FLG_MUTE]  = mute_d;
        rep_d.flags[FLG_VDN]   = btn_pressed[BTN_DN];
        rep_d.flags[FLG_VUP]   = btn_pressed[BTN_UP];
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            regs_q   <= REG_RST;
            st_q     <= ST_IDLE;
            req_q    <= '0;
            rep_q    <= '0;
            rvalid_q <= 1'b0;
            irq_q    <= 1'b0;
            mute_q   <= 1'b0;
            rec_q    <= 1'b0;
            src_q    <= '0;
        end else begin
            regs_q   <= regs_d;
            st_q     <= st_d;
            req_q    <= req_d;
            rep_q    <= rep_d;
            rvalid_q <= rvalid_d;
            irq_q    <= irq_d;
            mute_q   <= mute_d;
            rec_q    <= rec_d;
            src_q    <= src_d;
        end
    end

    assign in_report       = rep_q;
    assign in_report_valid = rvalid_q;
    assign ext_ctrl_irq_n  = ~irq_q;
    assign nvm_req         = req_q;
    assign nvm_req_valid   = (st_q == ST_REQ);
    assign record_silenced = rec_q;

    // ----------------------------------------------------------------
    // control outputs
    // ----------------------------------------------------------------
    audio_ctrl_s ctrl_q;
    audio_ctrl_s ctrl_d;
    logic        force_jack_sense_in;

    // the driver takes over routing once it sets its active bit
    assign force_jack_sense_in = jack_s && !regs_q[REG_OFS_MUTE][DRV_BIT];

    always_comb begin
        ctrl_d.spdif_out_ctrl_field      = regs_q[REG_OFS_SPDIF][12:0];
        ctrl_d.dac_double_rate_en        = regs_q[REG_OFS_AUDIO][15];
        ctrl_d.adc_full_scale_sel        = regs_q[REG_OFS_AUDIO][14];
        ctrl_d.pll_search_en             = regs_q[REG_OFS_AUDIO][13];
        ctrl_d.soft_silence_en           = regs_q[REG_OFS_AUDIO][12];
        ctrl_d.alt_lowpass_sel           = regs_q[REG_OFS_AUDIO][3];
        ctrl_d.digital_audio_loopback_en = regs_q[REG_OFS_AUDIO][2];
        ctrl_d.digital_audio_out_off     = regs_q[REG_OFS_AUDIO][1];
        ctrl_d.digital_audio_in_mix_en   = regs_q[REG_OFS_AUDIO][0];
        ctrl_d.mic_right_source_sel      = regs_q[REG_OFS_MUTE][MICR_BIT];
        ctrl_d.mic_bias_low_sel          = regs_q[REG_OFS_OUTEN][BIAS_BIT];
        ctrl_d.input_mix_routing_sel     = regs_q[REG_OFS_OUTEN][MIX_BIT];
        ctrl_d.pair_out_en               = regs_q[REG_OFS_OUTEN][OE_LO +: 5];
        if (force_jack_sense_in) begin
            ctrl_d.channel_silence_mask = FORCED_SILENCE;
            ctrl_d.jack_sense_in_source_sel    = FRONT_SOURCE;
        end else begin
            ctrl_d.channel_silence_mask = regs_q[REG_OFS_MUTE][SIL_LO +: 10];
            ctrl_d.jack_sense_in_source_sel    = regs_q[REG_OFS_MUTE][PSRC_LO +: 2];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    assign audio_ctrl = ctrl_q;

    for (genvar g = 0; g < 4; g++) begin : g_gp
        assign gp_pin_out[g]  = regs_q[REG_OFS_AUDIO][GP_VAL_LO + 2*g];
        assign gp_pin_oe_n[g] = ~regs_q[REG_OFS_AUDIO][GP_EN_LO + 2*g];
    end

    ext_clock_divider #(
        .SLOW_HALF (EXT_HALF)
    ) u_div (
        .clk     (clk),
        .resetn  (resetn),
        .sel     (regs_q[REG_OFS_MUTE][1:0]),
        .clk_out (ext_ctrl_clk)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence reg_access_s;
        out_report_valid && is_reg;
    endsequence

    sequence reg_read_s;
        reg_rd && !nvm_win;
    endsequence

    reg_read_report_a: assert property (
        reg_read_s |=> in_report_valid && in_report.flags[FLG_REG]
                       && ({in_report.hi, in_report.lo} == $past(rview)))
        else $error("register read did not produce its report");

    reg_write_a: assert property (
        reg_wr && ridx == REG_OFS_SPDIF |=> regs_q[0] == ($past(wword) & 16'h1fff))
        else $error("register 0 write not stored under mask");

    nvm_issue_a: assert property (
        nvm_go |=> nvm_req_valid && nvm_req.addr == $past(out_report.addr[5:0]))
        else $error("nonvolatile command not issued");

    one_source_a: assert property (
        in_report_valid |-> $onehot(in_report.flags[FLG_CTRL:FLG_REG]))
        else $error("report source flags not one-hot");

    vol_flags_a: assert property (
        ##1 in_report.flags[FLG_VUP] == $past(btn_pressed[BTN_UP])
            && in_report.flags[FLG_VDN] == $past(btn_pressed[BTN_DN]))
        else $error("volume flags do not follow buttons");

    mute_clear_a: assert property (
        in_report_valid && in_report_taken && !btn_press[BTN_PLAY]
        |=> !in_report.flags[FLG_MUTE])
        else $error("silence flag not cleared after read");

    jack_sense_in_flag_a: assert property (
        ##1 in_report.flags[FLG_PHONE] == $past(jack_s))
        else $error("jack_sense_in flag does not follow jack sense");

    forced_route_a: assert property (
        force_jack_sense_in |=> audio_ctrl.channel_silence_mask == 10'h0ff
                         && audio_ctrl.jack_sense_in_source_sel == 2'h0)
        else $error("jack_sense_in routing not forced");

    irq_low_a: assert property (
        reg_access_s |=> !ext_ctrl_irq_n [*1] ##1 (ext_ctrl_irq_n || !$past(mcu_read)
                                                  || $past(access)))
        else $error("controller irq not asserted on access");

    irq_release_a: assert property (
        mcu_read && !access |=> ext_ctrl_irq_n)
        else $error("controller irq not released after read");

    gp_drive_a: assert property (
        reg_wr && ridx == REG_OFS_AUDIO
        |=> gp_pin_oe_n == ~{$past(wword[10]), $past(wword[8]),
                             $past(wword[6]), $past(wword[4])}
            && gp_pin_out == {$past(wword[11]), $past(wword[9]),
                              $past(wword[7]), $past(wword[5])})
        else $error("gp pins do not follow register 1 write");

endmodule

//--- core/hid_bank_pkg.sv
// ----------------------------------------------------------------
// What this block does
// - reports 48 and 32 read and write registers 0 to 3, data low then high
// - reports 80 and 64 read and write nonvolatile words 0 to 63
// - every read returns its word in a three-byte input report, except a register read in the same cycle as nvm data
// - input byte 0 flags the word source; bytes 1 and 2 carry the word
// - volume flags follow the held, low-active volume buttons
// - play silence flag sets on press, clears once the host takes the report
// - jack_sense_in flag is high while the jack sense pin is high
// - all four buttons are debounced, then edge detected
// - register 0 holds a 13-bit digital out field and resets to zero
// - register 1 top four bits are audio enables; reset value b000
// - register 1 bits 11..4 hold value and drive enable per gp pin
// - register 1 bits 3..0 steer filter, loopback, out off, input mix
// - jack_sense_in present without driver forces all but jack_sense_in silent, front source
// - register 2 bits 14..13 pick the jack_sense_in source
// - register 2 bits 12..3 hold a per-channel silence mask
// - register 2 bit 2 picks mic right source; reset value 0004
// - register 2 bits 1..0 pick the controller clock rate
// - register 3 bit 10 picks the low mic bias level
// - register 3 bit 9 mixes inputs into front or all channels
// - register 3 bits 8..7 report the digital input rate, read only
// - register 3 bits 5..1 enable the five analog output pairs
// - register 3 bit 6 reports the package, read only
// - register 3 bit 0 reports whether digital input may be recorded
// - controller irq goes low on any access, high after controller read
// ----------------------------------------------------------------
package hid_bank_pkg;

    localparam logic [7:0] CMD_REG_RD   = 8'h30;
    localparam logic [7:0] CMD_REG_WR   = 8'h20;
    localparam logic [7:0] CMD_NVM_RD   = 8'h50;
    localparam logic [7:0] CMD_NVM_WR   = 8'h40;
    localparam logic [7:0] REG_ADDR_MAX = 8'h03;
    localparam logic [7:0] NVM_ADDR_MAX = 8'h3f;

    localparam logic [1:0] REG_OFS_SPDIF = 2'h0;
    localparam logic [1:0] REG_OFS_AUDIO = 2'h1;
    localparam logic [1:0] REG_OFS_MUTE  = 2'h2;
    localparam logic [1:0] REG_OFS_OUTEN = 2'h3;

    localparam logic [3:0][15:0] REG_RST     = {16'h003e, 16'h0004, 16'hb000, 16'h0000};
    localparam logic [3:0][15:0] REG_WR_MASK = {16'h063e, 16'hffff, 16'hffff, 16'h1fff};

    localparam int DRV_BIT   = 15;
    localparam int PSRC_LO   = 13;
    localparam int SIL_LO    = 3;
    localparam int MICR_BIT  = 2;
    localparam int BIAS_BIT  = 10;
    localparam int MIX_BIT   = 9;
    localparam int OE_LO     = 1;
    localparam int GP_VAL_LO = 5;
    localparam int GP_EN_LO  = 4;

    localparam logic [9:0] FORCED_SILENCE = 10'h0ff;
    localparam logic [1:0] FRONT_SOURCE   = 2'h0;

    localparam int FLG_CTRL  = 7;
    localparam int FLG_NVM   = 6;
    localparam int FLG_REG   = 5;
    localparam int FLG_PHONE = 4;
    localparam int FLG_MUTE  = 2;
    localparam int FLG_VDN   = 1;
    localparam int FLG_VUP   = 0;

    localparam int BTN_UP   = 0;
    localparam int BTN_DN   = 1;
    localparam int BTN_REC  = 2;
    localparam int BTN_PLAY = 3;
    localparam int NUM_BTN  = 4;

    localparam int CLK_KHZ          = 25000;
    localparam int DEBOUNCE_US      = 10000;
    localparam int DEBOUNCE_CYCLES  = DEBOUNCE_US * (CLK_KHZ / 1000);
    localparam int EXT_SLOW_KHZ     = 1500;
    localparam int EXT_SLOW_HALF    = CLK_KHZ / (2 * EXT_SLOW_KHZ);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_REQ  = 3'b010,
        ST_WAIT = 3'b100
    } nvm_state_e;

    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] lo;
        logic [7:0] hi;
        logic [7:0] addr;
    } out_report_s;

    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] lo;
        logic [7:0] hi;
    } in_report_s;

    typedef struct packed {
        logic        write;
        logic [5:0]  addr;
        logic [15:0] data;
    } nvm_req_s;

    typedef struct packed {
        logic [12:0] spdif_out_ctrl_field;
        logic        dac_double_rate_en;
        logic        adc_full_scale_sel;
        logic        pll_search_en;
        logic        soft_silence_en;
        logic        alt_lowpass_sel;
        logic        digital_audio_loopback_en;
        logic        digital_audio_out_off;
        logic        digital_audio_in_mix_en;
        logic [9:0]  channel_silence_mask;
        logic [1:0]  jack_sense_in_source_sel;
        logic        mic_right_source_sel;
        logic        mic_bias_low_sel;
        logic        input_mix_routing_sel;
        logic [4:0]  pair_out_en;
    } audio_ctrl_s;

endpackage

//--- core/button_filter.sv
`timescale 1ns/1ns
module button_filter #(
    parameter int N   = 4,
    parameter int CYC = 250000
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic [N-1:0] raw_n,
    output logic      [N-1:0] pressed,
    output logic      [N-1:0] press
);
    import hid_bank_pkg::*;

    if (CYC < 2) begin : g_chk
        $error("button_filter: CYC must be at least 2");
    end

    for (genvar i = 0; i < N; i++) begin : g_btn
        logic [31:0] cnt_q;
        logic [31:0] cnt_d;
        logic        lvl_q;
        logic        lvl_d;
        logic        edge_q;
        logic        edge_d;
        // a level must stay put for CYC cycles before the filtered level moves
        always_comb begin
            cnt_d  = '0;
            lvl_d  = lvl_q;
            edge_d = 1'b0;
            if (raw_n[i] != lvl_q) begin
                cnt_d = cnt_q + 32'h0000_0001;
                if (cnt_q == 32'(CYC - 1)) begin
                    cnt_d  = '0;
                    lvl_d  = ~lvl_q;
                    edge_d = lvl_q;
                end
            end
        end
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                cnt_q  <= '0;
                lvl_q  <= 1'b1;
                edge_q <= 1'b0;
            end else begin
                cnt_q  <= cnt_d;
                lvl_q  <= lvl_d;
                edge_q <= edge_d;
            end
        end
        assign pressed[i] = ~lvl_q;
        assign press[i]   = edge_q;
    end
endmodule

//--- core/ext_clock_divider.sv
`timescale 1ns/1ns
module ext_clock_divider #(
    parameter int SLOW_HALF = 8
) (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [1:0] sel,
    output logic            clk_out
);
    import hid_bank_pkg::*;

    if (SLOW_HALF < 8 || SLOW_HALF > 255) begin : g_chk
        $error("ext_clock_divider: SLOW_HALF must lie in 8..255");
    end

    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic       out_q;
    logic       out_d;
    logic [7:0] half;

    // each step of sel halves the period; fastest rate is limited by clk
    assign half = 8'(SLOW_HALF >> sel);

    always_comb begin
        cnt_d = cnt_q + 8'h01;
        out_d = out_q;
        if (cnt_q >= half - 8'h01) begin
            cnt_d = '0;
            out_d = ~out_q;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
            out_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            out_q <= out_d;
        end
    end

    assign clk_out = out_q;
endmodule

//--- verif/host_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// host side of the report pipe
// ----------------------------------------
module host_model (
    input  wire logic                 clk,
    output hid_bank_pkg::out_report_s out_report,
    output logic                      out_report_valid,
    output logic                      in_report_taken
);
    import hid_bank_pkg::*;
    initial begin
        out_report       = '0;
        out_report_valid = 1'b0;
        in_report_taken  = 1'b0;
    end
    // one-edge request; bytes scrambled afterwards so stale data never looks valid
    task automatic send(input logic [7:0] cmd, input logic [15:0] w, input logic [7:0] a);
        @(posedge clk);
        out_report       <= '{cmd, w[7:0], w[15:8], a};
        out_report_valid <= 1'b1;
        @(posedge clk);
        out_report_valid <= 1'b0;
        out_report       <= ~out_report;
    endtask
    task automatic take();
        @(posedge clk);
        in_report_taken <= 1'b1;
        @(posedge clk);
        in_report_taken <= 1'b0;
    endtask
endmodule

//--- verif/hid_register_access_bank_bench.sv
`timescale 1ns/1ns
module hid_register_access_bank_bench;
    import hid_bank_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, out_report_valid, in_report_valid, in_report_taken;
    logic mcu_word_valid = 1'b0, mcu_read = 1'b0, ext_ctrl_irq_n, ext_ctrl_clk, nvm_req_valid;
    logic nvm_req_ready = 1'b1, nvm_rsp_valid = 1'b0, jack_sense_in = 1'b0, record_silenced;
    logic vol_up_button_n = 1'b1, vol_down_button_n = 1'b1, record_silence_button_n = 1'b1;
    logic play_silence_button_n = 1'b1, package_indicator_in = 1'b0;
    logic digital_in_record_allowed = 1'b1, clk_seen;
    logic [15:0] mcu_word = 16'h0000, nvm_rsp_data = 16'h0000;
    logic [1:0]  digital_in_rate = 2'h2;
    logic [3:0]  gp_pin_out, gp_pin_oe_n;
    out_report_s out_report;
    in_report_s  in_report;
    nvm_req_s    nvm_req;
    audio_ctrl_s audio_ctrl;
    int          err_total = 0;
    int          comparisons = 0;
    always #20 clk = ~clk;
    host_model host (.clk, .out_report, .out_report_valid, .in_report_taken);
    // short debounce keeps button scenarios to a few dozen cycles
    hid_register_access_bank #(.DEBOUNCE_CYC(4), .EXT_HALF(8)) u_dut (.clk, .resetn,
        .out_report, .out_report_valid, .in_report, .in_report_valid, .in_report_taken,
        .mcu_word, .mcu_word_valid, .mcu_read, .ext_ctrl_irq_n, .ext_ctrl_clk, .nvm_req,
        .nvm_req_valid, .nvm_req_ready, .nvm_rsp_data, .nvm_rsp_valid, .vol_up_button_n,
        .vol_down_button_n, .record_silence_button_n, .play_silence_button_n, .jack_sense_in,
        .package_indicator_in, .digital_in_rate, .digital_in_record_allowed, .gp_pin_out,
        .gp_pin_oe_n, .audio_ctrl, .record_silenced);
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        host.send(CMD_REG_RD, 16'h0000, a);
        #1;
        chk("reg source", {in_report_valid, in_report.flags[7:5]}, 16'h0009);
        chk("reg word", {in_report.hi, in_report.lo}, exp);
        host.take();
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd(8'h00, 16'h0000);
        rd(8'h01, 16'hb000);
        rd(8'h02, 16'h0004);
        rd(8'h03, 16'h013f);
        chk("irq low", ext_ctrl_irq_n, 16'h0000);
        @(posedge clk) mcu_read <= 1'b1;
        @(posedge clk) mcu_read <= 1'b0;
        idle(1);
        chk("irq high", ext_ctrl_irq_n, 16'h0001);
        host.send(CMD_REG_WR, 16'hffff, 8'h00);
        host.send(CMD_REG_WR, 16'h1234, 8'h04);
        host.send(8'h31, 16'h1234, 8'h00);
        rd(8'h00, 16'h1fff);
        host.send(CMD_REG_WR, 16'hffff, 8'h03);
        package_indicator_in <= 1'b1;
        idle(4);
        rd(8'h03, 16'h077f);
        host.send(CMD_REG_WR, 16'h003a, 8'h01);
        idle(2);
        chk("gp pins", {gp_pin_oe_n, gp_pin_out}, 16'h00e1);
        chk("low ctrl", audio_ctrl[23:20], 16'h000a);
        host.send(CMD_NVM_RD, 16'h0000, 8'h3f);
        #1;
        chk("nvm req", {nvm_req_valid, nvm_req.write, nvm_req.addr}, 16'h00bf);
        @(posedge clk) {nvm_rsp_valid, nvm_rsp_data} <= {1'b1, 16'h5aa5};
        @(posedge clk) nvm_rsp_valid <= 1'b0;
        idle(2);
        chk("nvm word", {in_report.hi, in_report.lo}, 16'h5aa5);
        chk("nvm flag", in_report.flags[FLG_NVM], 16'h0001);
        host.take();
        host.send(CMD_NVM_WR, 16'h1357, 8'h05);
        #1;
        chk("nvm write", {nvm_req_valid, nvm_req.write, nvm_req.addr}, 16'h00c5);
        chk("nvm data", nvm_req.data, 16'h1357);
        {vol_up_button_n, play_silence_button_n, record_silence_button_n} <= 3'b000;
        idle(20);
        chk("held flags", in_report.flags[2:0], 16'h0005);
        chk("rec toggle", record_silenced, 16'h0001);
        {vol_up_button_n, vol_down_button_n, play_silence_button_n} <= 3'b101;
        idle(20);
        chk("down flags", in_report.flags[2:0], 16'h0006);
        @(posedge clk) {mcu_word_valid, mcu_word} <= {1'b1, 16'hc3a5};
        @(posedge clk) mcu_word_valid <= 1'b0;
        idle(1);
        chk("ctrl source", {in_report_valid, in_report.flags[7:5]}, 16'h000c);
        chk("ctrl word", {in_report.hi, in_report.lo}, 16'hc3a5);
        vol_down_button_n <= 1'b1;
        host.take();
        idle(20);
        chk("flags clear", in_report.flags[2:0], 16'h0000);
        vol_up_button_n <= 1'b0;
        idle(2);
        vol_up_button_n <= 1'b1;
        idle(20);
        chk("glitch", in_report.flags[2:0], 16'h0000);
        host.send(CMD_REG_WR, 16'h6000, 8'h02);
        jack_sense_in <= 1'b1;
        idle(6);
        chk("jack_sense_in flag", in_report.flags[FLG_PHONE], 16'h0001);
        chk("forced", {audio_ctrl.channel_silence_mask, audio_ctrl.jack_sense_in_source_sel}, 16'h03fc);
        clk_seen = ext_ctrl_clk;
        idle(8);
        chk("ext clk slow", ext_ctrl_clk, {15'h0000, ~clk_seen});
        host.send(CMD_REG_WR, 16'he00f, 8'h02);
        idle(3);
        chk("driver on", {audio_ctrl.channel_silence_mask, audio_ctrl.jack_sense_in_source_sel}, 16'h0007);
        clk_seen = ext_ctrl_clk;
        idle(1);
        chk("ext clk fast", ext_ctrl_clk, {15'h0000, ~clk_seen});
        final_report();
    end
    initial begin
        #2000000;
        err_total++;
        final_report();
    end
endmodule
